/* fcac_pkg.sv */
`default_nettype none
package fcac_pkg;
  // Register offsets on the microprocessor port
  localparam logic [11:0] FCAC_OFF_CRC_OPT = 12'h669;
  localparam logic [11:0] FCAC_OFF_ALARM = 12'h66A;
  localparam logic [11:0] FCAC_OFF_EST = 12'h66B;
  localparam logic [11:0] FCAC_OFF_SEST_HI = 12'h66C;
  localparam logic [11:0] FCAC_OFF_SEST_LO = 12'h66D;
  localparam logic [11:0] FCAC_OFF_LOC_EN = 12'h66E;
  localparam logic [7:0] FCAC_RESET_VAL = 8'h00;
  // Field positions of the CRC option register
  localparam int FCAC_CRC_DIR_BIT = 0;
  localparam int FCAC_CRC_LFA_BIT = 1;
  localparam int FCAC_CRC_MF_BIT = 2;
  localparam int FCAC_CRC_IW_BIT = 3;
  localparam int FCAC_CRC_REB_BIT = 4;
  localparam int FCAC_CRC_RA_BIT = 5;
  localparam int FCAC_CRC_RSA6_BIT = 6;
  localparam int FCAC_CRC_ASYM_BIT = 7;
  // Field positions of the alarm filter register
  localparam int FCAC_AF_SA6_BIT = 0;
  localparam int FCAC_AF_AIS_BIT = 1;
  localparam int FCAC_AF_FER_BIT = 2;
  localparam int FCAC_AF_LB_BIT = 3;
  localparam int FCAC_AF_REMOTE_ALARM_FILTER_BIT = 5;
  localparam int FCAC_AF_ESM_LO = 6;
  localparam int FCAC_AF_ESM_HI = 7;
  // Second evaluation selections
  localparam logic [1:0] FCAC_ESM_DEFAULT = 2'h0;
  localparam logic [1:0] FCAC_ESM_THRESH = 2'h1;
  localparam int FCAC_LOC_EN_W = 4;
  // Counts and limits
  localparam logic [9:0] FCAC_CRC_LIM_ESF = 10'h140;
  localparam logic [9:0] FCAC_CRC_LIM_CEPT = 10'h393;
  localparam logic [9:0] FCAC_REB_LIM = 10'h3DE;
  localparam logic [1:0] FCAC_A_RUN = 2'h3;
  localparam logic [15:0] FCAC_DEF_SES_CNT = 16'h0140;
  // Timers, in milliseconds, and the clock rate in kHz
  localparam int unsigned FCAC_CLK_KHZ = 100000;
  localparam int unsigned FCAC_T_MF_MS = 100;
  localparam int unsigned FCAC_T_IW_MS = 400;
  localparam int unsigned FCAC_T_MF_CYC = FCAC_T_MF_MS * FCAC_CLK_KHZ;
  localparam int unsigned FCAC_T_IW_CYC = FCAC_T_IW_MS * FCAC_CLK_KHZ;
  localparam int FCAC_TMR_W = 26;
endpackage : fcac_pkg
`default_nettype wire

/* fcac_cfg.sv */
// Summary of operation
// [R1] Bit7 and bit0 select CRC direction
// [R2] Excess CRC errors per second flag misalignment
// [R3] Bit2 with bit0 runs 100 ms timer
// [R4] Bit3 with bit0 runs 400 ms search
// [R5] Bits4-6 run 990 FAR_END_BLOCK_ERROR counter restarts
// [R6] Alarm bit0 picks Sa6 monitoring sync
// [R7] Alarm bit1 picks AIS detection criterion
// [R8] DS1: bit2 adds signaling framing errors
// [R9] CEPT: bit2 counts FAS errors only
// [R10] CEPT: bit3 selects nailed-up loopback
// [R11] A-bit filter sets and clears alarm
// [R12] Bits7:6 select second evaluation rules
// [R13] Below ES threshold is no errored second
// [R14] Zero ES threshold disables ES monitor
// [R15] SES threshold sixteen bits, two bytes
// [R16] Zero SES threshold disables SES monitor
// [R17] Local event enables, upper bits zero
// [R18] All registers reset to zero
// [R19] Enabled local event forces ES and SES
// [R20] Software keeps reserved bits at zero
`timescale 1ns/10ps
`default_nettype none
module fcac_cfg
  import fcac_pkg::*;
#(
  parameter int unsigned T_MF_CYC = FCAC_T_MF_CYC,
  parameter int unsigned T_IW_CYC = FCAC_T_IW_CYC
)
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // Register port, synchronous to SYS_CLK
  input wire logic [11:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Framer status and event strobes
  input wire logic CEPT_MODE,
  input wire logic SEC_TICK,
  input wire logic CRC_ERR,
  input wire logic ERR_EVT,
  input wire logic EVT_SLIP,
  input wire logic EVT_AIS,
  input wire logic EVT_LMFA,
  input wire logic EVT_LFA,
  input wire logic MF_SEARCH_START,
  input wire logic MF_ALIGNED,
  input wire logic REB_IN,
  input wire logic SA6_FE_CODE,
  input wire logic A_BIT_STB,
  input wire logic A_BIT_VAL,
  // Decoded configuration
  output logic CRC_TX_EN,
  output logic CRC_RX_EN,
  output logic SYNC_SA6_MON,
  output logic AIS_ITU_SEL,
  output logic FT_FS_BOTH,
  output logic FAS_ONLY_COUNT,
  output logic NAILED_LB_SEL,
  // Results
  output logic LFA_CRC,
  output logic TIMER_EXPIRED,
  output logic [9:0] REB_COUNT,
  output logic REMOTE_ALARM,
  output logic ES_FLAG,
  output logic BES_FLAG,
  output logic SES_FLAG
);

  typedef struct packed {
    logic [7:0] crc_opt;
    logic [7:0] alarm;
    logic [7:0] est;
    logic [7:0] sest_hi;
    logic [7:0] sest_lo;
    logic [FCAC_LOC_EN_W-1:0] loc_en;
    logic [7:0] rdata;
    logic [9:0] crc_cnt;
    logic lfa_crc;
    logic [FCAC_TMR_W-1:0] tmr;
    logic tmr_on;
    logic tmr_exp;
    logic [9:0] reb_cnt;
    logic [1:0] a_ones;
    logic [1:0] a_zeros;
    logic rfa;
    logic [15:0] evt_cnt;
    logic loc_hit;
    logic es;
    logic bes;
    logic ses;
  } fcac_state_type;

  fcac_state_type st_r;
  fcac_state_type st_nxt;

  // Saturating run counter for A-bit filtering
  function automatic logic [1:0] fcac_run(input logic [1:0] cnt, input logic hit);
    fcac_run = hit ? ((cnt == FCAC_A_RUN) ? cnt : 2'(cnt + 2'h1)) : 2'h0;
  endfunction : fcac_run

  logic crc4_on;
  logic [9:0] crc_lim;
  logic [1:0] esm;
  logic [15:0] sest;
  logic loc_now;
  logic reb_restart;
  logic [15:0] cnt_now;

  // Mode decode; CRC-4 options need bit 7 clear and bit 0 set
  assign crc4_on = st_r.crc_opt[FCAC_CRC_DIR_BIT] & ~st_r.crc_opt[FCAC_CRC_ASYM_BIT];
  assign crc_lim = CEPT_MODE ? FCAC_CRC_LIM_CEPT : FCAC_CRC_LIM_ESF; // [R2]
  assign esm = st_r.alarm[FCAC_AF_ESM_HI:FCAC_AF_ESM_LO]; // [R12]
  assign sest = {st_r.sest_hi, st_r.sest_lo}; // [R15]
  assign loc_now = |({EVT_SLIP, EVT_AIS, EVT_LMFA, EVT_LFA} & st_r.loc_en); // [R19]
  assign reb_restart = (st_r.crc_opt[FCAC_CRC_RA_BIT] & A_BIT_STB & A_BIT_VAL)
                     | (st_r.crc_opt[FCAC_CRC_RSA6_BIT] & SA6_FE_CODE); // [R5]
  assign cnt_now = st_r.evt_cnt;

  // Configuration outputs straight from the option registers
  assign CRC_TX_EN = st_r.crc_opt[FCAC_CRC_ASYM_BIT] ? ~st_r.crc_opt[FCAC_CRC_DIR_BIT]
                                                    : st_r.crc_opt[FCAC_CRC_DIR_BIT]; // [R1]
  assign CRC_RX_EN = st_r.crc_opt[FCAC_CRC_DIR_BIT]; // [R1]
  assign SYNC_SA6_MON = st_r.alarm[FCAC_AF_SA6_BIT]; // [R6]
  assign AIS_ITU_SEL = st_r.alarm[FCAC_AF_AIS_BIT]; // [R7]
  assign FT_FS_BOTH = ~CEPT_MODE & st_r.alarm[FCAC_AF_FER_BIT]; // [R8]
  assign FAS_ONLY_COUNT = CEPT_MODE & st_r.alarm[FCAC_AF_FER_BIT]; // [R9]
  assign NAILED_LB_SEL = CEPT_MODE & st_r.alarm[FCAC_AF_LB_BIT]; // [R10]
  assign REG_RDATA = st_r.rdata;
  assign LFA_CRC = st_r.lfa_crc;
  assign TIMER_EXPIRED = st_r.tmr_exp;
  assign REB_COUNT = st_r.reb_cnt;
  assign REMOTE_ALARM = st_r.rfa;
  assign ES_FLAG = st_r.es;
  assign BES_FLAG = st_r.bes;
  assign SES_FLAG = st_r.ses;

  // Next-state logic for the whole block
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.lfa_crc = 1'b0;
    st_nxt.tmr_exp = 1'b0;
    st_nxt.es = 1'b0;
    st_nxt.bes = 1'b0;
    st_nxt.ses = 1'b0;
    // Register writes; reserved alarm bit 4 is stored as written
    if (REG_WR)
    begin
      unique case (REG_ADDR)
        FCAC_OFF_CRC_OPT: st_nxt.crc_opt = REG_WDATA;
        FCAC_OFF_ALARM: st_nxt.alarm = REG_WDATA;
        FCAC_OFF_EST: st_nxt.est = REG_WDATA;
        FCAC_OFF_SEST_HI: st_nxt.sest_hi = REG_WDATA; // [R15]
        FCAC_OFF_SEST_LO: st_nxt.sest_lo = REG_WDATA; // [R15]
        FCAC_OFF_LOC_EN: st_nxt.loc_en = REG_WDATA[FCAC_LOC_EN_W-1:0]; // [R17]
        default: ;
      endcase
    end
    // Registered read data; unmapped addresses read zero
    if (REG_RD)
    begin
      unique case (REG_ADDR)
        FCAC_OFF_CRC_OPT: st_nxt.rdata = st_r.crc_opt;
        FCAC_OFF_ALARM: st_nxt.rdata = st_r.alarm;
        FCAC_OFF_EST: st_nxt.rdata = st_r.est;
        FCAC_OFF_SEST_HI: st_nxt.rdata = st_r.sest_hi;
        FCAC_OFF_SEST_LO: st_nxt.rdata = st_r.sest_lo;
        FCAC_OFF_LOC_EN: st_nxt.rdata = {4'h0, st_r.loc_en}; // [R17]
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    // CRC error count per second; one pulse when the limit is reached
    if (SEC_TICK)
      st_nxt.crc_cnt = {9'h000, CRC_ERR & crc4_on & st_r.crc_opt[FCAC_CRC_LFA_BIT]};
    else if (CRC_ERR && crc4_on && st_r.crc_opt[FCAC_CRC_LFA_BIT] && st_r.crc_cnt != crc_lim)
    begin
      st_nxt.crc_cnt = 10'(st_r.crc_cnt + 10'h001);
      st_nxt.lfa_crc = (10'(st_r.crc_cnt + 10'h001) == crc_lim); // [R2]
    end
    // Multiframe timer; interworking search takes the longer period
    if (!crc4_on || !(st_r.crc_opt[FCAC_CRC_MF_BIT] | st_r.crc_opt[FCAC_CRC_IW_BIT]) || MF_ALIGNED)
      st_nxt.tmr_on = 1'b0;
    else if (MF_SEARCH_START)
    begin
      st_nxt.tmr_on = 1'b1;
      st_nxt.tmr = st_r.crc_opt[FCAC_CRC_IW_BIT] ? FCAC_TMR_W'(T_IW_CYC - 1) // [R4]
                                                 : FCAC_TMR_W'(T_MF_CYC - 1); // [R3]
    end
    else if (st_r.tmr_on)
    begin
      if (st_r.tmr == '0)
      begin
        st_nxt.tmr_on = 1'b0;
        st_nxt.tmr_exp = 1'b1;
      end
      else
        st_nxt.tmr = FCAC_TMR_W'(st_r.tmr - 1'b1);
    end
    // Far-end block error counter saturates at its limit
    if (!(crc4_on && st_r.crc_opt[FCAC_CRC_REB_BIT]) || reb_restart)
      st_nxt.reb_cnt = 10'h000; // [R5]
    else if (REB_IN && st_r.reb_cnt != FCAC_REB_LIM)
      st_nxt.reb_cnt = 10'(st_r.reb_cnt + 10'h001); // [R5]
    // Remote alarm filter, CEPT only
    if (!CEPT_MODE)
    begin
      st_nxt.rfa = 1'b0;
      st_nxt.a_ones = 2'h0;
      st_nxt.a_zeros = 2'h0;
    end
    else if (A_BIT_STB)
    begin
      st_nxt.a_ones = fcac_run(st_r.a_ones, A_BIT_VAL);
      st_nxt.a_zeros = fcac_run(st_r.a_zeros, ~A_BIT_VAL);
      if (A_BIT_VAL && st_r.a_ones == 2'h2)
        st_nxt.rfa = 1'b1; // [R11]
      else if (!A_BIT_VAL && (st_r.alarm[FCAC_AF_REMOTE_ALARM_FILTER_BIT] || st_r.a_zeros == 2'h2))
        st_nxt.rfa = 1'b0; // [R11]
    end
    // Per-second errored event accounting; events in the tick cycle open the new second
    if (SEC_TICK)
    begin
      st_nxt.evt_cnt = {15'h0000, ERR_EVT};
      st_nxt.loc_hit = loc_now;
      unique case (esm)
        FCAC_ESM_DEFAULT:
        begin
          st_nxt.ses = st_r.loc_hit | (cnt_now >= FCAC_DEF_SES_CNT);
          st_nxt.es = st_r.loc_hit | (cnt_now != 16'h0000);
          st_nxt.bes = ~st_nxt.ses & (cnt_now > 16'h0001);
        end
        FCAC_ESM_THRESH:
        begin
          st_nxt.es = st_r.loc_hit | ((st_r.est != 8'h00) & (cnt_now > {8'h00, st_r.est})); // [R13] [R14] [R19]
          st_nxt.bes = 1'b0; // [R12]
          st_nxt.ses = st_r.loc_hit | ((sest != 16'h0000) & (cnt_now > sest)); // [R15] [R16] [R19]
        end
        default: ; // Reserved selections judge nothing
      endcase
    end
    else
    begin
      if (ERR_EVT && st_r.evt_cnt != 16'hFFFF)
        st_nxt.evt_cnt = 16'(st_r.evt_cnt + 16'h0001);
      st_nxt.loc_hit = st_r.loc_hit | loc_now; // [R19]
    end
  end

  // State register; every field clears on reset
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      st_r <= '0; // [R18]
    else
      st_r <= st_nxt;
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  AST_CRC_TX_ONLY: assert property ( // [R1]
    (REG_WR && REG_ADDR == FCAC_OFF_CRC_OPT && REG_WDATA == 8'h80) |=> (CRC_TX_EN && !CRC_RX_EN))
    else $error("CRC transmit-only option not applied");
  AST_LFA_AT_LIMIT: assert property ( // [R2]
    LFA_CRC |-> (st_r.crc_cnt == crc_lim && $past(CRC_ERR)))
    else $error("CRC alignment loss flagged off the limit");
  AST_TMR_LOAD: assert property ( // [R3]
    (MF_SEARCH_START && crc4_on && st_r.crc_opt[FCAC_CRC_MF_BIT] && !st_r.crc_opt[FCAC_CRC_IW_BIT]
     && !MF_ALIGNED) |=> (st_r.tmr_on && st_r.tmr == FCAC_TMR_W'(T_MF_CYC - 1)))
    else $error("Multiframe timer loaded wrongly");
  AST_IW_LOAD: assert property ( // [R4]
    (MF_SEARCH_START && crc4_on && st_r.crc_opt[FCAC_CRC_IW_BIT] && !MF_ALIGNED)
    |=> (st_r.tmr == FCAC_TMR_W'(T_IW_CYC - 1)))
    else $error("Interworking timer loaded wrongly");
  AST_REB_RESTART: assert property ( // [R5]
    reb_restart |=> (REB_COUNT == 10'h000 && $past(REB_COUNT) <= FCAC_REB_LIM))
    else $error("FAR_END_BLOCK_ERROR counter failed to restart");
  AST_RFA_RISE: assert property ( // [R11]
    $rose(REMOTE_ALARM) |-> $past(A_BIT_STB && A_BIT_VAL && st_r.a_ones == 2'h2))
    else $error("Remote alarm set without three ones");
  AST_BES_HELD: assert property ( // [R12]
    (SEC_TICK && esm == FCAC_ESM_THRESH) |=> !BES_FLAG)
    else $error("Bursty second flagged in threshold mode");
  AST_ES_BELOW: assert property ( // [R13]
    (SEC_TICK && esm == FCAC_ESM_THRESH && !st_r.loc_hit && st_r.evt_cnt < {8'h00, st_r.est}) |=> !ES_FLAG)
    else $error("Errored second below threshold");
  AST_SES_OFF: assert property ( // [R16]
    (SEC_TICK && esm == FCAC_ESM_THRESH && !st_r.loc_hit && sest == 16'h0000) |=> !SES_FLAG)
    else $error("Severe monitor active at zero threshold");
  AST_LOC_FORCE: assert property ( // [R19]
    (SEC_TICK && esm == FCAC_ESM_THRESH && st_r.loc_hit) |=> (ES_FLAG && SES_FLAG))
    else $error("Local event did not force ES and SES");
  AST_LOC_READ: assert property ( // [R17]
    (REG_RD && REG_ADDR == FCAC_OFF_LOC_EN) |=> (REG_RDATA[7:4] == 4'h0))
    else $error("Local enable upper bits not zero");

endmodule : fcac_cfg
`default_nettype wire

/* fcac_cfg_test.sv */
`timescale 1ns/10ps
`default_nettype none
module fcac_cfg_test;
  import fcac_pkg::*;
  localparam int TMF = 20;
  localparam int TIW = 40;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic cept_mode = 1'b0;
  logic mf_aligned = 1'b0;
  logic a_bit_val = 1'b0;
  // Strobes: 0 crc, 1 err, 2 slip, 3 ais, 4 lmfa, 5 lfa, 6 start, 7 reb, 8 sa6, 9 abit, 10 tick
  logic [10:0] stb = 11'h000;
  logic crc_tx_en, crc_rx_en, sync_sa6_mon, ais_itu_sel, ft_fs_both, fas_only_count, nailed_lb_sel;
  logic lfa_crc, timer_expired, remote_alarm, es_flag, bes_flag, ses_flag;
  logic [9:0] reb_count;
  int n_fail = 0;
  int check_count = 0;
  int n_lfa = 0;
  int n_tmr = 0;
  int cycles = 0;

  always #5 sys_clk = ~sys_clk;

  fcac_cfg #(.T_MF_CYC(TMF), .T_IW_CYC(TIW)) DUT (
    .SYS_CLK(sys_clk), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .CEPT_MODE(cept_mode), .SEC_TICK(stb[10]),
    .CRC_ERR(stb[0]), .ERR_EVT(stb[1]), .EVT_SLIP(stb[2]), .EVT_AIS(stb[3]), .EVT_LMFA(stb[4]),
    .EVT_LFA(stb[5]), .MF_SEARCH_START(stb[6]), .MF_ALIGNED(mf_aligned), .REB_IN(stb[7]),
    .SA6_FE_CODE(stb[8]), .A_BIT_STB(stb[9]), .A_BIT_VAL(a_bit_val), .CRC_TX_EN(crc_tx_en),
    .CRC_RX_EN(crc_rx_en), .SYNC_SA6_MON(sync_sa6_mon), .AIS_ITU_SEL(ais_itu_sel),
    .FT_FS_BOTH(ft_fs_both), .FAS_ONLY_COUNT(fas_only_count), .NAILED_LB_SEL(nailed_lb_sel),
    .LFA_CRC(lfa_crc), .TIMER_EXPIRED(timer_expired), .REB_COUNT(reb_count),
    .REMOTE_ALARM(remote_alarm), .ES_FLAG(es_flag), .BES_FLAG(bes_flag), .SES_FLAG(ses_flag)
  );

  // One-cycle pulses are counted so a late or doubled pulse shows up
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (lfa_crc === 1'b1) n_lfa <= n_lfa + 1;
    if (timer_expired === 1'b1) n_tmr <= n_tmr + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Register port: strobe high for exactly one edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", 10'(reg_rdata), 10'(exp));
  endtask : rd

  // One idle edge, then back-to-back pulses on one strobe
  task automatic ev(input int b, input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      stb[b] <= 1'b1;
    end
    @(posedge sys_clk);
    stb <= 11'h000;
  endtask : ev

  // Events of one second, then the boundary; flags read as {ES, BES, SES}
  task automatic sec(input int b, input int n, input logic [2:0] exp);
    ev(b, n);
    ev(10, 1);
    #1;
    chk("flags", 10'({es_flag, bes_flag, ses_flag}), 10'(exp));
  endtask : sec

  task automatic tmr(input logic [7:0] opt, input int t, input logic stop);
    int p;
    wr(FCAC_OFF_CRC_OPT, opt);
    p = n_tmr;
    ev(6, 1);
    mf_aligned <= stop;
    // Pulse stands T+1 edges after the start edge; look on both sides of it
    repeat (t) @(posedge sys_clk);
    #1 chk("tmr_early", 10'(n_tmr - p), 10'h000);
    @(posedge sys_clk);
    #1 chk("tmr", 10'(n_tmr - p), stop ? 10'h000 : 10'h001);
    @(posedge sys_clk);
    mf_aligned <= 1'b0;
  endtask : tmr

  task automatic ab(input logic v, input int n, input logic exp);
    @(posedge sys_clk);
    a_bit_val <= v;
    ev(9, n);
    #1;
    chk("remote_alarm", 10'(remote_alarm), 10'(exp));
  endtask : ab

  initial
  begin
    int p;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    // Reset values, then full-ones write; upper enable bits are not kept
    for (int i = 0; i < 6; i++) rd(FCAC_OFF_CRC_OPT + 12'(i), FCAC_RESET_VAL);
    // Alarm filter gets a legal pattern: reserved bit 4 and selections 1x stay clear
    for (int i = 0; i < 6; i++) wr(FCAC_OFF_CRC_OPT + 12'(i), i == 1 ? 8'h6F : 8'hFF);
    for (int i = 0; i < 6; i++) rd(FCAC_OFF_CRC_OPT + 12'(i), i == 5 ? 8'h0F : (i == 1 ? 8'h6F : 8'hFF));
    wr(12'h66F, 8'h55);
    rd(12'h66F, 8'h00);
    // CRC direction decode
    wr(FCAC_OFF_CRC_OPT, 8'h00);
    #1 chk("crc_dir", 10'({crc_tx_en, crc_rx_en}), 10'h000);
    wr(FCAC_OFF_CRC_OPT, 8'h80);
    #1 chk("crc_dir", 10'({crc_tx_en, crc_rx_en}), 10'h002);
    wr(FCAC_OFF_CRC_OPT, 8'h81);
    #1 chk("crc_dir", 10'({crc_tx_en, crc_rx_en}), 10'h001);
    // Alarm filter decodes in both line modes
    wr(FCAC_OFF_ALARM, 8'h0F);
    #1 chk("ds1_decodes", 10'({ft_fs_both, fas_only_count, nailed_lb_sel}), 10'h004);
    @(posedge sys_clk);
    cept_mode <= 1'b1;
    @(posedge sys_clk);
    #1 chk("decodes", 10'({ft_fs_both, sync_sa6_mon, ais_itu_sel, fas_only_count, nailed_lb_sel}), 10'h00F);
    wr(FCAC_OFF_ALARM, 8'h00);
    #1 chk("decodes", 10'({ft_fs_both, sync_sa6_mon, ais_itu_sel, fas_only_count, nailed_lb_sel}), 10'h000);
    // Per-second CRC limit, DS1 then CEPT
    wr(FCAC_OFF_CRC_OPT, 8'h03);
    for (int m = 0; m < 2; m++)
    begin
      @(posedge sys_clk);
      cept_mode <= m[0];
      ev(10, 1);
      p = n_lfa;
      ev(0, (m == 0 ? 320 : 915) - 1);
      // Pulse counter updates on the edge itself; look just after it
      @(posedge sys_clk);
      #1 chk("lfa_early", 10'(n_lfa - p), 10'h000);
      ev(0, 1);
      @(posedge sys_clk);
      #1 chk("lfa", 10'(n_lfa - p), 10'h001);
    end
    // Multiframe and interworking timers
    tmr(8'h05, TMF, 1'b0);
    tmr(8'h09, TIW, 1'b0);
    tmr(8'h0D, TIW, 1'b0);
    tmr(8'h05, TMF, 1'b1);
    // Far-end block error counter and its restarts
    wr(FCAC_OFF_CRC_OPT, 8'h31);
    ev(7, 5);
    #1 chk("reb", reb_count, 10'd5);
    ab(1'b1, 1, 1'b0);
    chk("reb", reb_count, 10'd0);
    wr(FCAC_OFF_CRC_OPT, 8'h51);
    ev(7, 2);
    ev(8, 1);
    #1 chk("reb", reb_count, 10'd0);
    ev(7, 995);
    #1 chk("reb_sat", reb_count, 10'd990);
    // Remote alarm filtering, three-in-a-row then single clear; a zero first breaks the earlier run of ones
    ab(1'b0, 1, 1'b0);
    ab(1'b1, 2, 1'b0);
    ab(1'b1, 1, 1'b1);
    ab(1'b0, 2, 1'b1);
    ab(1'b0, 1, 1'b0);
    wr(FCAC_OFF_ALARM, 8'h20);
    ab(1'b1, 3, 1'b1);
    ab(1'b0, 1, 1'b0);
    // Second evaluation, threshold mode
    wr(FCAC_OFF_ALARM, 8'h40);
    wr(FCAC_OFF_EST, 8'h02);
    wr(FCAC_OFF_SEST_LO, 8'h03);
    wr(FCAC_OFF_SEST_HI, 8'h00);
    sec(1, 0, 3'b000);
    sec(1, 2, 3'b000);
    sec(1, 3, 3'b100);
    sec(1, 4, 3'b101);
    wr(FCAC_OFF_SEST_HI, 8'h01);
    sec(1, 4, 3'b100);
    wr(FCAC_OFF_EST, 8'h00);
    wr(FCAC_OFF_SEST_HI, 8'h00);
    wr(FCAC_OFF_SEST_LO, 8'h00);
    sec(1, 9, 3'b000);
    // Local events count only when enabled, and one suffices
    wr(FCAC_OFF_LOC_EN, 8'h01);
    sec(5, 1, 3'b101);
    sec(2, 1, 3'b000);
    wr(FCAC_OFF_LOC_EN, 8'h0F);
    for (int b = 2; b < 6; b++) sec(b, 1, 3'b101);
    // Default evaluation mode
    wr(FCAC_OFF_ALARM, 8'h00);
    sec(1, 2, 3'b110);
    // Default severe count, both sides of its end point
    sec(1, 319, 3'b110);
    sec(1, 320, 3'b101);
    close_out();
  end
endmodule : fcac_cfg_test
`default_nettype wire
